// file: common/dtc_defs.svh
// constants for the diagnostic and tape command executor
// assumes inclusion by bare name from design files
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

// command codes written to the command location
`define DTC_CMD_ABORT      8'h00
`define DTC_CMD_WR_GAP     8'h8A
`define DTC_CMD_VERIFY     8'h8B
`define DTC_CMD_RD_LONG    8'h8C
`define DTC_CMD_WR_LONG    8'h8D
`define DTC_CMD_COMP_ERR   8'h8E
`define DTC_CMD_COMP_LONG  8'h8F
// location of the command register
`define DTC_CMD_LOC        8'h3F
// read status register 0D and its data-mismatch bit
`define DTC_STAT_LOC       8'h0D
`define DTC_STAT_MISM_BIT  3
// correction spans in bits
`define DTC_SPAN_32_NORM   5'h05
`define DTC_SPAN_56_NORM   5'h0B
`define DTC_SPAN_32_LONG   5'h0B
`define DTC_SPAN_56_LONG   5'h16
// widths and reset values
`define DTC_SYN_W          56
`define DTC_ZERO_BYTE      8'h00
`define DTC_RST_COUNT      8'h00
`define DTC_RST_SPAN       5'h00

`endif

// file: common/dtc_pkg.sv
// types shared by the command executor files
// assumes dtc_defs.svh is on the include path
package dtc_pkg;

    // command execution states
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_GAP     = 3'b001,
        ST_VERIFY  = 3'b010,
        ST_RD_LONG = 3'b011,
        ST_WR_LONG = 3'b100,
        ST_COMPUTE = 3'b101
    } dtc_state_t;

    // control state of the executor
    typedef struct packed {
        dtc_state_t  st;
        logic [7:0]  count;
        logic        gate;
        logic        mism;
        logic        id_err;
        logic        dat_err;
        logic [7:0]  mem_byte;
        logic        mem_vld;
        logic [7:0]  wr_byte;
        logic        wr_vld;
        logic        orient;
        logic        comp_go;
        logic [4:0]  span;
        logic        done;
    } dtc_ctl_t;

    // state of the syndrome capture shifter
    typedef struct packed {
        logic [55:0] syn;
    } dtc_syn_t;

endpackage

// file: logic/dtc_syn_cap.sv
// syndrome capture: shifts raw ecc bytes read from the medium
// assumes one byte per shift strobe, oldest byte ends in the top
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_syn_cap (
    // clock, reset, enable
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   ce_in,
    // control and data
    input  wire logic                   clear_in,
    input  wire logic                   shift_in,
    input  wire logic [7:0]             byte_in,
    // captured bits
    output logic [`DTC_SYN_W-1:0]       syn_out
);
    dtc_pkg::dtc_syn_t s_q;
    dtc_pkg::dtc_syn_t s_d;

    ////////////////////////////////////////////////////////////////////
    // next value: clear wins, else shift a byte in
    always_comb begin
        s_d = s_q;
        if (clear_in) begin
            s_d.syn = '0;
        end else if (shift_in) begin
            s_d.syn = {s_q.syn[`DTC_SYN_W-9:0], byte_in};
        end
    end

    // register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
        end else if (ce_in) begin
            s_q <= s_d;
        end
    end

    assign syn_out = s_q.syn;

endmodule // dtc_syn_cap

// file: logic/dtc_cmd_exec.sv
// command executor for gap write, verify, long read/write, compute error
// assumes the drive channel hands bytes already deserialised, one strobe each
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_cmd_exec (
    // clock, reset, enable
    input  wire logic                   clk_sys_in,
    input  wire logic                   reset_n_in,
    input  wire logic                   ce_in,
    // command location write from the host
    input  wire logic                   cmd_wr_in,
    input  wire logic [7:0]             cmd_addr_in,
    input  wire logic [7:0]             cmd_code_in,
    input  wire logic [7:0]             xfer_count_in,
    input  wire logic                   ecc56_in,
    // drive channel events and read bytes
    input  wire logic                   index_in,
    input  wire logic                   disk_vld_in,
    input  wire logic [7:0]             disk_byte_in,
    input  wire logic                   disk_ecc_in,
    input  wire logic                   id_ecc_err_in,
    input  wire logic                   dat_ecc_err_in,
    input  wire logic                   sector_end_in,
    // memory side bytes from dma
    input  wire logic                   mem_vld_in,
    input  wire logic [7:0]             mem_byte_in,
    // ecc engine completion
    input  wire logic                   comp_done_in,
    // bytes to memory
    output logic                        mem_vld_out,
    output logic [7:0]                  mem_byte_out,
    // bytes to the medium
    output logic                        wr_vld_out,
    output logic [7:0]                  wr_byte_out,
    output logic                        write_gate_out,
    output logic                        ecc_gen_off_out,
    output logic                        orient_reset_out,
    // ecc engine request
    output logic                        comp_go_out,
    output logic [4:0]                  comp_span_out,
    // status
    output logic                        busy_out,
    output logic                        done_out,
    output logic [7:0]                  count_out,
    output logic [7:0]                  status_0d_out,
    output logic                        id_err_out,
    output logic                        dat_err_out,
    output logic [`DTC_SYN_W-1:0]       syn_out
);
    dtc_pkg::dtc_ctl_t c_q;
    dtc_pkg::dtc_ctl_t c_d;
    logic              start;
    logic              syn_clear;
    logic              syn_shift;

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic dtc_pkg::dtc_state_t cmd_state(input logic [7:0] code);
        case (code)
            `DTC_CMD_WR_GAP:    cmd_state = dtc_pkg::ST_GAP;
            `DTC_CMD_VERIFY:    cmd_state = dtc_pkg::ST_VERIFY;
            `DTC_CMD_RD_LONG:   cmd_state = dtc_pkg::ST_RD_LONG;
            `DTC_CMD_WR_LONG:   cmd_state = dtc_pkg::ST_WR_LONG;
            `DTC_CMD_COMP_ERR, `DTC_CMD_COMP_LONG: cmd_state = dtc_pkg::ST_COMPUTE;
            default:            cmd_state = dtc_pkg::ST_IDLE;
        endcase
    endfunction

    function automatic logic [4:0] span_of(input logic [7:0] code, input logic e56);
        if (code == `DTC_CMD_COMP_LONG) span_of = e56 ? `DTC_SPAN_56_LONG : `DTC_SPAN_32_LONG;
        else span_of = e56 ? `DTC_SPAN_56_NORM : `DTC_SPAN_32_NORM;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // command acceptance: only a write to the command location
    assign start = cmd_wr_in && (cmd_addr_in == `DTC_CMD_LOC);

    // next state
    always_comb begin
        c_d         = c_q;
        c_d.mem_vld = 1'b0;
        c_d.wr_vld  = 1'b0;
        c_d.orient  = 1'b0;
        c_d.comp_go = 1'b0;
        c_d.done    = 1'b0;
        if (start) begin
            // any new command, abort included, ends the running one
            c_d.st      = cmd_state(cmd_code_in);
            c_d.count   = xfer_count_in;
            c_d.gate    = (cmd_code_in == `DTC_CMD_WR_GAP)
                          || (cmd_code_in == `DTC_CMD_WR_LONG);
            c_d.mism    = 1'b0;
            c_d.id_err  = 1'b0;
            c_d.dat_err = 1'b0;
            c_d.wr_byte = `DTC_ZERO_BYTE;
            c_d.done    = (c_q.st != dtc_pkg::ST_IDLE);
            c_d.orient  = (cmd_code_in == `DTC_CMD_WR_GAP);
            if (cmd_state(cmd_code_in) == dtc_pkg::ST_COMPUTE) begin
                c_d.comp_go = 1'b1;
                c_d.span    = span_of(cmd_code_in, ecc56_in);
            end
        end else begin
            case (c_q.st)
                dtc_pkg::ST_IDLE: c_d.gate = 1'b0;
                dtc_pkg::ST_GAP: begin
                    // zeroes every cycle until index
                    c_d.wr_vld  = 1'b1;
                    c_d.wr_byte = `DTC_ZERO_BYTE;
                    if (index_in) begin
                        c_d.st     = dtc_pkg::ST_IDLE;
                        c_d.gate   = 1'b0;
                        c_d.wr_vld = 1'b0;
                        c_d.done   = 1'b1;
                    end
                end
                dtc_pkg::ST_VERIFY: begin
                    if (disk_vld_in && mem_vld_in && (disk_byte_in != mem_byte_in)) begin
                        c_d.mism = 1'b1;
                        c_d.st   = dtc_pkg::ST_IDLE;
                        c_d.done = 1'b1;
                    end else if (sector_end_in) begin
                        if (c_q.count == `DTC_RST_COUNT) begin
                            c_d.st   = dtc_pkg::ST_IDLE;
                            c_d.done = 1'b1;
                        end else begin
                            c_d.count = c_q.count - 8'h01;
                        end
                    end
                end
                dtc_pkg::ST_RD_LONG: begin
                    // data and ecc bytes go to memory, id error or not
                    if (disk_vld_in) begin
                        c_d.mem_vld  = 1'b1;
                        c_d.mem_byte = disk_byte_in;
                    end
                    c_d.id_err  = c_q.id_err | id_ecc_err_in;
                    c_d.dat_err = c_q.dat_err | dat_ecc_err_in;
                    if (sector_end_in) begin
                        if (c_q.id_err || c_q.dat_err || id_ecc_err_in || dat_ecc_err_in) begin
                            c_d.st   = dtc_pkg::ST_IDLE;
                            c_d.done = 1'b1;
                        end else if (c_q.count == `DTC_RST_COUNT) begin
                            c_d.st   = dtc_pkg::ST_IDLE;
                            c_d.done = 1'b1;
                        end else begin
                            c_d.count = c_q.count - 8'h01;
                        end
                    end
                end
                dtc_pkg::ST_WR_LONG: begin
                    // memory bytes straight to the medium, id errors ignored
                    c_d.gate = 1'b1;
                    if (mem_vld_in) begin
                        c_d.wr_vld  = 1'b1;
                        c_d.wr_byte = mem_byte_in;
                    end
                    if (sector_end_in) begin
                        if (c_q.count == `DTC_RST_COUNT) begin
                            c_d.st   = dtc_pkg::ST_IDLE;
                            c_d.gate = 1'b0;
                            c_d.done = 1'b1;
                        end else begin
                            c_d.count = c_q.count - 8'h01;
                        end
                    end
                end
                dtc_pkg::ST_COMPUTE: begin
                    if (comp_done_in) begin
                        c_d.st   = dtc_pkg::ST_IDLE;
                        c_d.done = 1'b1;
                    end
                end
                default: begin
                    c_d.st   = dtc_pkg::ST_IDLE;
                    c_d.gate = 1'b0;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            c_q       <= '0;
            c_q.st    <= dtc_pkg::ST_IDLE;
            c_q.count <= `DTC_RST_COUNT;
            c_q.span  <= `DTC_RST_SPAN;
        end else if (ce_in) begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // raw ecc bytes of a long read land in the syndrome register
    assign syn_clear = start && (cmd_code_in == `DTC_CMD_RD_LONG);
    assign syn_shift = (c_q.st == dtc_pkg::ST_RD_LONG) && disk_vld_in
                       && disk_ecc_in && !start;

    dtc_syn_cap u_syn (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .ce_in      (ce_in),
        .clear_in   (syn_clear),
        .shift_in   (syn_shift),
        .byte_in    (disk_byte_in),
        .syn_out    (syn_out)
    );

    ////////////////////////////////////////////////////////////////////
    // outputs from the state register
    assign mem_vld_out      = c_q.mem_vld;
    assign mem_byte_out     = c_q.mem_byte;
    assign wr_vld_out       = c_q.wr_vld;
    assign wr_byte_out      = c_q.wr_byte;
    assign write_gate_out   = c_q.gate;
    assign ecc_gen_off_out  = (c_q.st == dtc_pkg::ST_WR_LONG);
    assign orient_reset_out = c_q.orient;
    assign comp_go_out      = c_q.comp_go;
    assign comp_span_out    = c_q.span;
    assign busy_out         = (c_q.st != dtc_pkg::ST_IDLE);
    assign done_out         = c_q.done;
    assign count_out        = c_q.count;
    assign status_0d_out    = {4'h0, c_q.mism, 3'h0};
    assign id_err_out       = c_q.id_err;
    assign dat_err_out      = c_q.dat_err;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    AST_GAP_START: assert property (
        ce_in && start && cmd_code_in == `DTC_CMD_WR_GAP
        |=> orient_reset_out && write_gate_out && busy_out)
        else $error("gap command did not start zero writing");
    AST_GAP_ZERO: assert property (
        ce_in && c_q.st == dtc_pkg::ST_GAP && !start && !index_in
        |=> wr_vld_out && wr_byte_out == 8'h00)
        else $error("gap write produced no zero byte");
    AST_GAP_END: assert property (
        ce_in && c_q.st == dtc_pkg::ST_GAP && !start && index_in
        |=> !write_gate_out && !busy_out && done_out)
        else $error("gap write did not end at index");
    AST_MISMATCH: assert property (
        ce_in && !start && c_q.st == dtc_pkg::ST_VERIFY && disk_vld_in && mem_vld_in
        && disk_byte_in != mem_byte_in |=> status_0d_out[`DTC_STAT_MISM_BIT] && !busy_out)
        else $error("verify mismatch not flagged");
    AST_RDL_FWD: assert property (
        ce_in && !start && c_q.st == dtc_pkg::ST_RD_LONG && disk_vld_in
        |=> mem_vld_out && mem_byte_out == $past(disk_byte_in))
        else $error("long read byte not forwarded");
    AST_RDL_STOP: assert property (
        ce_in && !start && c_q.st == dtc_pkg::ST_RD_LONG && sector_end_in
        && (id_err_out || dat_err_out) |=> !busy_out)
        else $error("long read ran past an ecc error");
    AST_ABORT: assert property (
        ce_in && start && cmd_code_in == `DTC_CMD_ABORT |=> !busy_out && !write_gate_out)
        else $error("abort did not stop the operation");
    AST_COUNT_DEC: assert property (
        ce_in && !start && c_q.st == dtc_pkg::ST_WR_LONG && sector_end_in
        && count_out != 8'h00 |=> count_out == $past(count_out) - 8'h01)
        else $error("count did not decrement");
    AST_SPAN_LONG: assert property (
        ce_in && start && cmd_code_in == `DTC_CMD_COMP_LONG && ecc56_in
        |=> comp_go_out && comp_span_out == 5'h16)
        else $error("wrong long span");
    AST_SPAN_NORM: assert property (
        ce_in && start && cmd_code_in == `DTC_CMD_COMP_ERR && !ecc56_in
        |=> comp_go_out && comp_span_out == 5'h05)
        else $error("wrong normal span");

    COV_GAP_INDEX: cover property (c_q.st == dtc_pkg::ST_GAP ##1 index_in);
    COV_MISMATCH: cover property (status_0d_out[`DTC_STAT_MISM_BIT]);
    COV_RDL_ERR: cover property (c_q.st == dtc_pkg::ST_RD_LONG && id_err_out && sector_end_in);

endmodule // dtc_cmd_exec

// file: tb/dtc_drive_model.sv
// drive read channel model: read bytes, ecc bytes and track events
// assumes the bench calls its tasks and shares the system clock
`timescale 1ns/1ps

module dtc_drive_model (
    // clock
    input  wire logic       clk_sys_in,
    // channel toward the executor
    output logic            disk_vld_out,
    output logic [7:0]      disk_byte_out,
    output logic            disk_ecc_out,
    output logic [3:0]      event_out
);
    ////////////////////////////////////////////////////////////////////////////
    // quiet channel at time zero
    initial begin
        disk_vld_out  = 1'b0;
        disk_byte_out = 8'h5a;
        disk_ecc_out  = 1'b0;
        event_out     = 4'h0;
    end

    // one read byte per call, held until the next call or event
    task automatic put(input logic [7:0] b, input logic e);
        @(posedge clk_sys_in);
        disk_vld_out  <= 1'b1;
        disk_byte_out <= b;
        disk_ecc_out  <= e;
    endtask

    // one-cycle event {index, id err, data err, sector end}; byte lines toggle
    task automatic ev(input logic [3:0] e);
        @(posedge clk_sys_in);
        disk_vld_out  <= 1'b0;
        disk_byte_out <= ~disk_byte_out;
        disk_ecc_out  <= 1'b0;
        event_out     <= e;
        @(posedge clk_sys_in);
        event_out     <= 4'h0;
        disk_byte_out <= ~disk_byte_out;
    endtask
endmodule // dtc_drive_model

// file: tb/dtc_cmd_exec_tb.sv
// self-checking bench for the diagnostic and tape command executor
// assumes dtc_defs.svh on the include path and the drive model beside it
`timescale 1ns/1ps
`include "dtc_defs.svh"

module dtc_cmd_exec_tb;
    // bench-driven inputs
    logic        clk_sys_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic        cmd_wr_in = 1'b0;
    logic [7:0]  cmd_addr_in = 8'h00;
    logic [7:0]  cmd_code_in = 8'h00;
    logic [7:0]  xfer_count_in = 8'h00;
    logic        ecc56_in = 1'b0;
    logic        mem_vld_in = 1'b0;
    logic [7:0]  mem_byte_in = 8'ha5;
    logic        comp_done_in = 1'b0;
    logic        ce_in = 1'b1;
    // drive model lines
    logic        disk_vld, disk_ecc;
    logic [7:0]  disk_byte;
    logic [3:0]  ev;
    // design outputs
    logic        mem_vld_out, wr_vld_out, write_gate_out, ecc_gen_off_out;
    logic        orient_reset_out, comp_go_out, busy_out, done_out, id_err_out, dat_err_out;
    logic [7:0]  mem_byte_out, wr_byte_out, count_out, status_0d_out;
    logic [4:0]  comp_span_out;
    logic [55:0] syn_out;
    // reference model state
    int          error_cnt = 0;
    int          num_checks = 0;
    logic [7:0]  exp_q [$];
    logic [55:0] syn_m;
    logic [4:0]  spans [4] = '{5'h05, 5'h0b, 5'h0b, 5'h16};

    ////////////////////////////////////////////////////////////////////////////
    // clock
    always #5 clk_sys_in = ~clk_sys_in;

    dtc_drive_model drv (.clk_sys_in(clk_sys_in), .disk_vld_out(disk_vld),
        .disk_byte_out(disk_byte), .disk_ecc_out(disk_ecc), .event_out(ev));

    dtc_cmd_exec DUT (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
        .cmd_wr_in(cmd_wr_in), .cmd_addr_in(cmd_addr_in), .cmd_code_in(cmd_code_in),
        .xfer_count_in(xfer_count_in), .ecc56_in(ecc56_in), .index_in(ev[3]),
        .disk_vld_in(disk_vld), .disk_byte_in(disk_byte), .disk_ecc_in(disk_ecc),
        .id_ecc_err_in(ev[2]), .dat_ecc_err_in(ev[1]), .sector_end_in(ev[0]),
        .mem_vld_in(mem_vld_in), .mem_byte_in(mem_byte_in), .comp_done_in(comp_done_in),
        .mem_vld_out(mem_vld_out), .mem_byte_out(mem_byte_out), .wr_vld_out(wr_vld_out),
        .wr_byte_out(wr_byte_out), .write_gate_out(write_gate_out),
        .ecc_gen_off_out(ecc_gen_off_out), .orient_reset_out(orient_reset_out),
        .comp_go_out(comp_go_out), .comp_span_out(comp_span_out), .busy_out(busy_out),
        .done_out(done_out), .count_out(count_out), .status_0d_out(status_0d_out),
        .id_err_out(id_err_out), .dat_err_out(dat_err_out), .syn_out(syn_out));

    ////////////////////////////////////////////////////////////////////////////
    // compare and report
    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // every byte sent to memory must be the next one expected
    always @(negedge clk_sys_in) begin
        if (mem_vld_out === 1'b1) begin
            if (exp_q.size() == 0) chk_val(mem_byte_out, 9'h100);
            else chk_val(mem_byte_out, exp_q.pop_front());
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host write of one location, outputs settled on return
    task automatic cmd(input logic [7:0] a, input logic [7:0] c, input logic [7:0] n);
        @(posedge clk_sys_in);
        cmd_wr_in     <= 1'b1;
        cmd_addr_in   <= a;
        cmd_code_in   <= c;
        xfer_count_in <= n;
        @(posedge clk_sys_in);
        cmd_wr_in     <= 1'b0;
        #1;
    endtask

    // bounded wait for the executor to go idle
    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            @(negedge clk_sys_in);
            if (busy_out === 1'b0) break;
        end
        if (busy_out !== 1'b0) begin
            chk_val(busy_out, 1'b0);
            results();
        end
    endtask

    // one read sector: event before, 4 data and 7 ecc bytes, event after
    task automatic rsector(input logic [3:0] pre, input logic [3:0] post);
        logic [7:0] b;
        drv.ev(pre);
        for (int i = 0; i < 11; i++) begin
            b = 8'($urandom);
            exp_q.push_back(b);
            if (i > 3) syn_m = {syn_m[47:0], b};
            drv.put(b, i > 3);
        end
        drv.ev(post);
    endtask

    // verify sector: disk and memory bytes paired in one cycle
    task automatic vsector(input int bad);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            b = 8'($urandom);
            fork
                drv.put(b, 1'b0);
                begin
                    @(posedge clk_sys_in);
                    mem_vld_in  <= 1'b1;
                    mem_byte_in <= (i == bad) ? ~b : b;
                end
            join
        end
        fork
            drv.ev(4'h1);
            begin
                @(posedge clk_sys_in);
                mem_vld_in  <= 1'b0;
                mem_byte_in <= ~mem_byte_in;
            end
        join
        @(negedge clk_sys_in);
    endtask

    // memory byte in long write, forwarded to the medium next cycle
    task automatic mbyte(input logic [7:0] b);
        @(posedge clk_sys_in);
        mem_vld_in  <= 1'b1;
        mem_byte_in <= b;
        @(posedge clk_sys_in);
        mem_vld_in  <= 1'b0;
        mem_byte_in <= ~b;
        #1 chk_val({write_gate_out, wr_vld_out, wr_byte_out}, {2'b11, b});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(21));
        repeat (5) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        // gap write ended by index
        cmd(`DTC_CMD_LOC, `DTC_CMD_WR_GAP, 8'h00);
        chk_val({orient_reset_out, write_gate_out}, 2'b11);
        @(posedge clk_sys_in);
        repeat (3) begin
            @(negedge clk_sys_in);
            chk_val({wr_vld_out, wr_byte_out}, 9'h100);
        end
        // clock enable low: the index pulse goes unseen, writing stays frozen
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        drv.ev(4'h8);
        @(negedge clk_sys_in);
        chk_val({busy_out, write_gate_out, wr_vld_out}, 3'h7);
        @(posedge clk_sys_in);
        ce_in <= 1'b1;
        drv.ev(4'h8);
        wait_idle();
        chk_val({done_out, write_gate_out, wr_vld_out}, 3'h4);
        // gap write halted by abort
        cmd(`DTC_CMD_LOC, `DTC_CMD_WR_GAP, 8'h00);
        cmd(`DTC_CMD_LOC, `DTC_CMD_ABORT, 8'h00);
        chk_val({busy_out, write_gate_out, done_out}, 3'h1);
        // other locations start nothing
        cmd(8'h3e, `DTC_CMD_WR_GAP, 8'h00);
        chk_val({busy_out, write_gate_out}, 2'b00);
        // compute commands, each ending a running gap write
        for (int k = 0; k < 4; k++) begin
            ecc56_in <= k[0];
            cmd(`DTC_CMD_LOC, `DTC_CMD_WR_GAP, 8'h00);
            cmd(`DTC_CMD_LOC, k[1] ? `DTC_CMD_COMP_LONG : `DTC_CMD_COMP_ERR, 8'h00);
            chk_val({done_out, write_gate_out, comp_go_out}, 3'h5);
            chk_val(comp_span_out, spans[k]);
            @(posedge clk_sys_in);
            comp_done_in <= 1'b1;
            @(posedge clk_sys_in);
            comp_done_in <= 1'b0;
            wait_idle();
        end
        // verify: clean sector counts down, then a mismatch ends it
        cmd(`DTC_CMD_LOC, `DTC_CMD_VERIFY, 8'h01);
        vsector(9);
        chk_val({busy_out, count_out, status_0d_out}, 17'h1_0000);
        vsector(2);
        wait_idle();
        chk_val(status_0d_out, 8'h08);
        // long read: clean sector, then id or data ecc error sector
        for (int k = 0; k < 2; k++) begin
            syn_m = 56'h0;
            cmd(`DTC_CMD_LOC, `DTC_CMD_RD_LONG, 8'h02);
            rsector(4'h0, 4'h1);
            @(negedge clk_sys_in);
            chk_val({busy_out, count_out}, 9'h101);
            rsector(k ? 4'h0 : 4'h4, k ? 4'h3 : 4'h1);
            wait_idle();
            chk_val({id_err_out, dat_err_out}, k ? 2'b01 : 2'b10);
            chk_val(count_out, 8'h01);
            chk_val(exp_q.size(), 0);
            chk_val(syn_out, syn_m);
        end
        // long write with an id ecc error on the sector
        cmd(`DTC_CMD_LOC, `DTC_CMD_WR_LONG, 8'h01);
        chk_val({busy_out, ecc_gen_off_out}, 2'b11);
        drv.ev(4'h4);
        for (int i = 0; i < 6; i++) mbyte(8'($urandom));
        drv.ev(4'h1);
        @(negedge clk_sys_in);
        chk_val({write_gate_out, busy_out, count_out}, 10'h300);
        drv.ev(4'h1);
        wait_idle();
        chk_val({write_gate_out, ecc_gen_off_out}, 2'b00);
        results();
    end
endmodule // dtc_cmd_exec_tb
